// [common/debug_cmd_regs.vh]
`ifndef DEBUG_CMD_REGS_VH
`define DEBUG_CMD_REGS_VH
// Command codes
`define CMD_ACK_ON 8'hD5
`define CMD_ACK_OFF 8'hD6
`define CMD_ENTER_BG 8'h90
`define CMD_STAT_FETCH 8'hE4
`define CMD_CTRL_LOAD 8'hC4
`define CMD_MEM_FETCH 8'hE0
`define CMD_MEM_FETCH_STAT 8'hE1
`define CMD_LAST_FETCH 8'hE8
`define CMD_MEM_STORE 8'hC0
`define CMD_MEM_STORE_STAT 8'hC1
`define CMD_MATCH_FETCH 8'hE2
`define CMD_MATCH_LOAD 8'hC2
`define CMD_RESUME 8'h08
`define CMD_STEP 8'h10
`define CMD_RESUME_TAG 8'h18
`define CMD_ACC_FETCH 8'h68
`define CMD_FLAGS_FETCH 8'h69
`define CMD_PC_FETCH 8'h6B
`define CMD_INDEX_FETCH 8'h6C
`define CMD_SP_FETCH 8'h6F
`define CMD_INCR_FETCH 8'h70
`define CMD_INCR_FETCH_STAT 8'h71
`define CMD_ACC_LOAD 8'h48
`define CMD_FLAGS_LOAD 8'h49
`define CMD_PC_LOAD 8'h4B
`define CMD_INDEX_LOAD 8'h4C
`define CMD_SP_LOAD 8'h4F
`define CMD_INCR_STORE 8'h50
`define CMD_INCR_STORE_STAT 8'h51
// Status/control field positions
`define SC_ENABLE_BIT 7
`define SC_ACTIVE_BIT 6
`define SC_BKPT_EN_BIT 5
`define SC_FTS_BIT 4
`define SC_ACK_BIT 3
`define SC_RESET 8'h00
// Timing counts in debug clock cycles
`define T_BIT 16
`define T_SAMPLE 10
`define T_DRIVE_LOW 13
`define T_SPEEDUP_ONE 7
`define T_DELAY 16
`define T_TIMEOUT 512
`define T_SYNC_DETECT 128
`define T_SYNC_WAIT 16
`define T_SYNC_LOW 128
`endif

// [hdl/debug_bit_engine.v]
`timescale 1ns/1ps
`default_nettype none
`include "debug_cmd_regs.vh"
// Bit-level pin engine: receives or sends one bit per host falling edge,
// answers sync requests and flags the inter-edge timeout.
module debug_bit_engine (
	input wire clk_sys_i,
	input wire rst_i,
	input wire pin_i,
	output reg pin_o,
	output reg pin_oe_o,
	input wire tx_en_i,
	input wire tx_bit_i,
	output reg bit_done_o,
	output reg bit_val_o,
	output reg timeout_o,
	output reg sync_o
);
	localparam S_IDLE = 3'h0;
	localparam S_BIT = 3'h1;
	localparam S_LOWWAIT = 3'h2;
	localparam S_SWAIT = 3'h3;
	localparam S_SLOW = 3'h4;
	localparam S_SPULSE = 3'h5;

	reg [2:0] st_q;
	reg [9:0] cnt_q;
	reg [9:0] idle_q;
	reg pin_q;
	reg tx_q;
	wire fall = pin_q & ~pin_i;

	// ----------------------------------------
	// Bit timing and sync
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_q <= S_IDLE;
			cnt_q <= 10'h000;
			idle_q <= 10'h000;
			pin_q <= 1'b1;
			tx_q <= 1'b0;
			pin_o <= 1'b1;
			pin_oe_o <= 1'b0;
			bit_done_o <= 1'b0;
			bit_val_o <= 1'b0;
			timeout_o <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			pin_q <= pin_i;
			bit_done_o <= 1'b0;
			timeout_o <= 1'b0;
			sync_o <= 1'b0;
			// Timeout between host edges
			if (fall)
				idle_q <= 10'h000;
			else if (idle_q == `T_TIMEOUT - 1) begin
				idle_q <= 10'h000;
				timeout_o <= 1'b1;
			end else
				idle_q <= idle_q + 10'h001;
			case (st_q)
				S_IDLE: begin
					pin_oe_o <= 1'b0;
					if (fall) begin
						st_q <= S_BIT;
						cnt_q <= 10'h001;
						tx_q <= tx_en_i;
						bit_val_o <= tx_bit_i;
					end
				end
				S_BIT: begin
					cnt_q <= cnt_q + 10'h001;
					if (tx_q) begin
						// Zero: hold low 12 cycles then speed-up pulse
						if (!bit_val_o && cnt_q < `T_DRIVE_LOW) begin
							pin_o <= 1'b0;
							pin_oe_o <= 1'b1;
						end else if (cnt_q == `T_DRIVE_LOW && !bit_val_o) begin
							pin_o <= 1'b1;
						end else if (cnt_q == `T_SPEEDUP_ONE && bit_val_o) begin
							pin_o <= 1'b1;
							pin_oe_o <= 1'b1;
						end else
							pin_oe_o <= 1'b0;
					end else if (cnt_q == `T_SAMPLE) begin
						bit_val_o <= pin_i;
					end
					if (!tx_q && !pin_i && cnt_q >= `T_BIT)
						st_q <= S_LOWWAIT;
					else if (cnt_q == `T_BIT - 1 && (tx_q || pin_i)) begin
						st_q <= S_IDLE;
						pin_oe_o <= 1'b0;
						bit_done_o <= 1'b1;
					end
				end
				S_LOWWAIT: begin
					// Long low: sync request if past threshold, else glitch
					cnt_q <= cnt_q + 10'h001;
					if (pin_i) begin
						st_q <= (cnt_q >= `T_SYNC_DETECT) ? S_SWAIT : S_IDLE;
						cnt_q <= 10'h000;
					end
				end
				S_SWAIT: begin
					cnt_q <= cnt_q + 10'h001;
					if (cnt_q == `T_SYNC_WAIT - 1) begin
						st_q <= S_SLOW;
						cnt_q <= 10'h000;
						sync_o <= 1'b1;
					end
				end
				S_SLOW: begin
					pin_o <= 1'b0;
					pin_oe_o <= 1'b1;
					cnt_q <= cnt_q + 10'h001;
					if (cnt_q == `T_SYNC_LOW - 1)
						st_q <= S_SPULSE;
				end
				S_SPULSE: begin
					pin_o <= 1'b1;
					pin_oe_o <= 1'b1;
					st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// [hdl/debug_cmd_unit.v]
`timescale 1ns/1ps
`default_nettype none
`include "debug_cmd_regs.vh"
// How it works
// - Each command opens with an 8-bit code, most significant bit first.
// - Delay slots last 16 debug clocks while the internal access completes.
// - Fields have fixed widths: 16-bit address, 8/16-bit data, 8-bit status.
// - Speed discovery has no code and works at any speed.
// - Code 90 enters background mode only when debug mode is enabled.
// - Codes D5 and D6 turn acknowledge mode on and off anytime.
// - E4 returns status/control; C4 writes the following control byte.
// - E0 reads a memory byte at an address; C0 writes one.
// - E1 and C1 behave likewise and also return status.
// - E8 returns status then re-reads the last read address.
// - E2 returns and C2 loads the 16-bit breakpoint match value.
// - 08 and 18 resume the program; 10 steps one instruction.
// - Register reads after delay: A, flags 8 bits; PC, index, SP 16 bits.
// - Register writes take data then delay with the same widths.
// - 70 and 71 increment index then read; 71 adds status.
// - 50 and 51 increment index then write; 51 adds status.
// - Device waits high, 16 cycles, drives 128 low, 1-cycle high pulse.
// - Breakpoint compares address bus; forced at boundary, tagged on opcode.
// - Breakpoint enable gates all requests and resets to zero.
// - Force/tag select: 1 forced, 0 tagged.
// - Bits last 16 cycles; received bits sampled ten cycles after edge.
// - 512 cycles without host edge aborts the command without side effects.
// - Sending zero drives low 12 cycles then a brief high pulse.
// - Non-intrusive commands run anytime; active ones only in background.
module debug_cmd_unit (
	input wire clk_sys_i,
	input wire rst_i,
	input wire debug_pin_i,
	output wire debug_pin_o,
	output wire debug_pin_oe_o,
	// Memory access port, one-cycle request, data ready next cycle
	output reg mem_req_o,
	output reg mem_we_o,
	output reg [15:0] mem_addr_o,
	output reg [7:0] mem_wdata_o,
	input wire [7:0] mem_rdata_i,
	// CPU register view and control
	input wire [7:0] cpu_acc_i,
	input wire [7:0] cpu_flags_i,
	input wire [15:0] cpu_pc_i,
	input wire [15:0] cpu_index_i,
	input wire [15:0] cpu_sp_i,
	output reg [2:0] cpu_reg_sel_o,
	output reg [15:0] cpu_reg_wdata_o,
	output reg cpu_reg_we_o,
	output reg cpu_resume_o,
	output reg cpu_step_o,
	input wire cpu_halted_i,
	input wire [15:0] cpu_addr_i,
	input wire cpu_opfetch_i,
	input wire cpu_access_i,
	output reg bkpt_force_o,
	output reg bkpt_tag_o,
	output reg background_req_o,
	output reg ack_mode_o
);
	localparam C_IDLE = 3'h0;
	localparam C_RX = 3'h1;
	localparam C_DELAY = 3'h2;
	localparam C_TX = 3'h3;

	reg [2:0] st_q;
	reg [7:0] code_q;
	reg [2:0] phase_q;
	reg [4:0] nbits_q;
	reg [15:0] sh_q;
	reg [15:0] addr_q;
	reg [15:0] last_q;
	reg [15:0] match_q;
	reg [7:0] sc_q;
	reg [4:0] dly_q;
	wire tx_bit = sh_q[15];
	wire bit_done;
	wire bit_val;
	wire tmo;
	wire sync_seen;
	wire tx_en = (st_q == C_TX);

	// Active-only command decode
	function is_active_cmd(input [7:0] c);
		is_active_cmd = (c[7:6] == 2'b00) | (c[7:6] == 2'b01);
	endfunction
	// Width of the 16-bit register commands
	function is_wide(input [7:0] c);
		is_wide = (c[2:0] == 3'h3) | (c[2:0] == 3'h4) | (c[2:0] == 3'h7);
	endfunction

	debug_bit_engine u_bits (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.pin_i(debug_pin_i),
		.pin_o(debug_pin_o),
		.pin_oe_o(debug_pin_oe_o),
		.tx_en_i(tx_en),
		.tx_bit_i(tx_bit),
		.bit_done_o(bit_done),
		.bit_val_o(bit_val),
		.timeout_o(tmo),
		.sync_o(sync_seen)
	);

	// ----------------------------------------
	// Breakpoint unit
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			bkpt_force_o <= 1'b0;
			bkpt_tag_o <= 1'b0;
		end else begin
			bkpt_force_o <= sc_q[`SC_BKPT_EN_BIT] & sc_q[`SC_FTS_BIT]
				& cpu_access_i & (cpu_addr_i == match_q);
			bkpt_tag_o <= sc_q[`SC_BKPT_EN_BIT] & ~sc_q[`SC_FTS_BIT]
				& cpu_opfetch_i & (cpu_addr_i == match_q);
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// phase: 0 code, 1 address, 2 write data, 3 delay/act, 4 status, 5 read data
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_q <= C_IDLE;
			code_q <= 8'h00;
			phase_q <= 3'h0;
			nbits_q <= 5'h00;
			sh_q <= 16'h0000;
			addr_q <= 16'h0000;
			last_q <= 16'h0000;
			match_q <= 16'h0000;
			sc_q <= `SC_RESET;
			dly_q <= 5'h00;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 8'h00;
			cpu_reg_sel_o <= 3'h0;
			cpu_reg_wdata_o <= 16'h0000;
			cpu_reg_we_o <= 1'b0;
			cpu_resume_o <= 1'b0;
			cpu_step_o <= 1'b0;
			background_req_o <= 1'b0;
			ack_mode_o <= 1'b0;
		end else begin
			mem_req_o <= 1'b0;
			cpu_reg_we_o <= 1'b0;
			cpu_resume_o <= 1'b0;
			cpu_step_o <= 1'b0;
			background_req_o <= 1'b0;
			sc_q[`SC_ACTIVE_BIT] <= cpu_halted_i;
			ack_mode_o <= sc_q[`SC_ACK_BIT];
			if (tmo || sync_seen) begin
				st_q <= C_IDLE;
			end else case (st_q)
				C_IDLE: begin
					st_q <= C_RX;
					phase_q <= 3'h0;
					nbits_q <= 5'd8;
				end
				C_RX: if (bit_done) begin
					sh_q <= {sh_q[14:0], bit_val};
					nbits_q <= nbits_q - 5'h01;
					if (nbits_q == 5'h01) begin
						if (phase_q == 3'h0) begin
							code_q <= {sh_q[6:0], bit_val};
							phase_q <= 3'h7; // decode next cycle
							st_q <= C_DELAY;
							dly_q <= 5'h00;
						end else if (phase_q == 3'h1) begin
							addr_q <= {sh_q[14:0], bit_val};
							// Bit 5 tells a read (no data field) from a write
							phase_q <= code_q[5] ? 3'h3 : 3'h2;
							nbits_q <= code_q[5] ? 5'h00 : 5'd8;
							st_q <= code_q[5] ? C_DELAY : C_RX;
							dly_q <= 5'h00;
						end else begin
							sh_q <= {sh_q[14:0], bit_val};
							phase_q <= 3'h3;
							st_q <= C_DELAY;
							dly_q <= 5'h00;
						end
					end
				end
				C_DELAY: begin
					if (phase_q == 3'h7) begin
						// Decode the freshly received code
						st_q <= C_RX;
						if (is_active_cmd(code_q) && !cpu_halted_i)
							st_q <= C_IDLE;
						else case (code_q)
							`CMD_MEM_FETCH, `CMD_MEM_FETCH_STAT, `CMD_MEM_STORE,
							`CMD_MEM_STORE_STAT: begin
								phase_q <= 3'h1;
								nbits_q <= 5'd16;
							end
							`CMD_CTRL_LOAD, `CMD_ACC_LOAD, `CMD_FLAGS_LOAD,
							`CMD_INCR_STORE, `CMD_INCR_STORE_STAT: begin
								phase_q <= 3'h2;
								nbits_q <= 5'd8;
							end
							`CMD_MATCH_LOAD, `CMD_PC_LOAD, `CMD_INDEX_LOAD,
							`CMD_SP_LOAD: begin
								phase_q <= 3'h2;
								nbits_q <= 5'd16;
							end
							`CMD_ACK_ON, `CMD_ACK_OFF, `CMD_ENTER_BG, `CMD_RESUME,
							`CMD_STEP, `CMD_RESUME_TAG, `CMD_ACC_FETCH,
							`CMD_FLAGS_FETCH, `CMD_PC_FETCH, `CMD_INDEX_FETCH,
							`CMD_SP_FETCH, `CMD_INCR_FETCH, `CMD_INCR_FETCH_STAT,
							`CMD_STAT_FETCH, `CMD_LAST_FETCH,
							`CMD_MATCH_FETCH: begin
								phase_q <= 3'h3;
								st_q <= C_DELAY;
							end
							default: nbits_q <= 5'h1F; // wait for timeout
						endcase
					end else if (phase_q == 3'h3) begin
						dly_q <= dly_q + 5'h01;
						// Act on the first cycle, release after the delay slot
						if (dly_q == 5'h00) begin
							case (code_q)
								`CMD_ACK_ON: sc_q[`SC_ACK_BIT] <= 1'b1;
								`CMD_ACK_OFF: sc_q[`SC_ACK_BIT] <= 1'b0;
								`CMD_ENTER_BG: background_req_o <= sc_q[`SC_ENABLE_BIT];
								`CMD_CTRL_LOAD: sc_q <= {sh_q[7], 1'b0, sh_q[5:0]};
								`CMD_MATCH_LOAD: match_q <= sh_q;
								`CMD_RESUME, `CMD_RESUME_TAG: cpu_resume_o <= 1'b1;
								`CMD_STEP: cpu_step_o <= 1'b1;
								`CMD_MEM_FETCH, `CMD_MEM_FETCH_STAT, `CMD_LAST_FETCH,
								`CMD_INCR_FETCH, `CMD_INCR_FETCH_STAT: begin
									mem_req_o <= 1'b1;
									mem_we_o <= 1'b0;
									mem_addr_o <= (code_q == `CMD_LAST_FETCH) ? last_q :
										(code_q[7] ? addr_q : cpu_index_i + 16'h0001);
									last_q <= (code_q == `CMD_LAST_FETCH) ? last_q :
										(code_q[7] ? addr_q : cpu_index_i + 16'h0001);
									if (!code_q[7]) begin
										cpu_reg_sel_o <= 3'h4;
										cpu_reg_wdata_o <= cpu_index_i + 16'h0001;
										cpu_reg_we_o <= 1'b1;
									end
								end
								`CMD_MEM_STORE, `CMD_MEM_STORE_STAT, `CMD_INCR_STORE,
								`CMD_INCR_STORE_STAT: begin
									mem_req_o <= 1'b1;
									mem_we_o <= 1'b1;
									mem_wdata_o <= sh_q[7:0];
									mem_addr_o <= code_q[7] ? addr_q : cpu_index_i + 16'h0001;
									if (!code_q[7]) begin
										cpu_reg_sel_o <= 3'h4;
										cpu_reg_wdata_o <= cpu_index_i + 16'h0001;
										cpu_reg_we_o <= 1'b1;
									end
								end
								`CMD_ACC_LOAD, `CMD_FLAGS_LOAD, `CMD_PC_LOAD,
								`CMD_INDEX_LOAD, `CMD_SP_LOAD: begin
									cpu_reg_sel_o <= code_q[2:0];
									cpu_reg_wdata_o <= sh_q;
									cpu_reg_we_o <= 1'b1;
								end
								default: ;
							endcase
						end
						if (dly_q == `T_DELAY - 1 || code_q == `CMD_STAT_FETCH ||
							code_q == `CMD_LAST_FETCH || code_q == `CMD_MATCH_FETCH ||
							code_q == `CMD_CTRL_LOAD || code_q == `CMD_MATCH_LOAD) begin
							// Choose the outgoing field after the delay slot, or at once for E4, E8, E2, C4 and C2
							st_q <= C_TX;
							phase_q <= 3'h5;
							nbits_q <= 5'd8;
							case (code_q)
								`CMD_STAT_FETCH, `CMD_MEM_FETCH_STAT, `CMD_LAST_FETCH,
								`CMD_MEM_STORE_STAT, `CMD_INCR_FETCH_STAT,
								`CMD_INCR_STORE_STAT: begin
									sh_q <= {sc_q, 8'h00};
									phase_q <= 3'h4;
								end
								`CMD_MATCH_FETCH: begin
									sh_q <= match_q;
									nbits_q <= 5'd16;
								end
								`CMD_MEM_FETCH, `CMD_INCR_FETCH: sh_q <= {mem_rdata_i, 8'h00};
								`CMD_ACC_FETCH: sh_q <= {cpu_acc_i, 8'h00};
								`CMD_FLAGS_FETCH: sh_q <= {cpu_flags_i, 8'h00};
								`CMD_PC_FETCH, `CMD_INDEX_FETCH, `CMD_SP_FETCH: begin
									sh_q <= (code_q == `CMD_PC_FETCH) ? cpu_pc_i :
										(code_q == `CMD_SP_FETCH) ? cpu_sp_i : cpu_index_i;
									nbits_q <= 5'd16;
								end
								default: st_q <= C_IDLE;
							endcase
						end
					end
				end
				C_TX: if (bit_done) begin
					sh_q <= {sh_q[14:0], 1'b0};
					nbits_q <= nbits_q - 5'h01;
					if (nbits_q == 5'h01) begin
						// Status then data for the combined reads
						if (phase_q == 3'h4 && (code_q == `CMD_MEM_FETCH_STAT ||
							code_q == `CMD_LAST_FETCH || code_q == `CMD_INCR_FETCH_STAT)) begin
							sh_q <= {mem_rdata_i, 8'h00};
							nbits_q <= 5'd8;
							phase_q <= 3'h5;
						end else
							st_q <= C_IDLE;
					end
				end
				default: st_q <= C_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// [sim/debug_host_pod.sv]
`timescale 1ns/1ps
`default_nettype none
module debug_host_pod (
	input wire logic clk_sys_i,
	input wire logic pin_i,
	output logic drive_low_o
);
	// ----
	// Bit slots of 22 cycles
	// ----
	initial drive_low_o = 1'b0;
	task automatic slot(input int hold, output logic s);
		drive_low_o <= 1'b1; // Host edge opens every bit
		for (int i = 0; i < 22; i++) begin
			@(posedge clk_sys_i);
			if (i == hold) drive_low_o <= 1'b0;
			if (i == 11) s = pin_i;
		end
	endtask
	// Fixed-width fields, most significant bit first
	task automatic xfer(input logic [15:0] v, input int n, input logic rx, output logic [15:0] q);
		logic s;
		q = 16'h0000;
		for (int k = n - 1; k >= 0; k--) begin
			slot(rx ? 1 : (v[k] ? 2 : 14), s);
			q[k] = s;
		end
	endtask
	task automatic send8(input logic [7:0] v);
		logic [15:0] q;
		xfer({8'h00, v}, 8, 1'b0, q);
	endtask
	task automatic send16(input logic [15:0] v);
		logic [15:0] q;
		xfer(v, 16, 1'b0, q);
	endtask
	task automatic recv8(output logic [7:0] r);
		logic [15:0] q;
		xfer(16'h0000, 8, 1'b1, q);
		r = q[7:0];
	endtask
	task automatic recv16(output logic [15:0] r);
		xfer(16'h0000, 16, 1'b1, r);
	endtask
	// Delay slot, longer than the 16 cycles asked
	task automatic gap();
		repeat (24) @(posedge clk_sys_i);
	endtask
	// Speed request with no code; release lets the pull-up raise the line
	task automatic sync(output int n);
		drive_low_o <= 1'b1;
		repeat (160) @(posedge clk_sys_i);
		drive_low_o <= 1'b0;
		n = 0;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk_sys_i);
			if (!pin_i) n++; // Low time of the reply
		end
	endtask
endmodule
`default_nettype wire

// [sim/debug_cmd_unit_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module debug_cmd_unit_chk (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic debug_pin_o,
	input wire logic debug_pin_oe_o,
	input wire logic mem_req_o,
	input wire logic cpu_reg_we_o,
	input wire logic cpu_resume_o,
	input wire logic cpu_step_o,
	input wire logic cpu_halted_i,
	input wire logic cpu_opfetch_i,
	input wire logic cpu_access_i,
	input wire logic bkpt_force_o,
	input wire logic bkpt_tag_o,
	input wire logic background_req_o
);
	logic [7:0] low_run_q;
	logic drv_low;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// ----
	// Length of each driven low stretch
	// ----
	assign drv_low = debug_pin_oe_o & ~debug_pin_o;
	always @(posedge clk_sys_i) begin
		if (rst_i || !drv_low) begin
			low_run_q <= 8'h00;
		end else begin
			low_run_q <= low_run_q + 8'h01;
		end
	end
	// ----
	// Properties
	// ----
	a_low_width: assert property ($fell(drv_low) |-> low_run_q == 8'h0C || low_run_q == 8'h80)
		else $error("driven low stretch has wrong length");
	a_speedup_after_low: assert property ($fell(drv_low) |-> debug_pin_oe_o && debug_pin_o)
		else $error("no high pulse after low drive");
	a_speedup_single: assert property (debug_pin_oe_o && debug_pin_o |=> !debug_pin_oe_o)
		else $error("high pulse longer than one cycle");
	a_mem_req_pulse: assert property (mem_req_o |=> !mem_req_o)
		else $error("memory request longer than one cycle");
	a_run_only_halted: assert property (cpu_resume_o || cpu_step_o |-> $past(cpu_halted_i))
		else $error("resume or step while running");
	a_regwe_halted: assert property (cpu_reg_we_o |-> $past(cpu_halted_i))
		else $error("register write while running");
	a_tag_on_fetch: assert property (bkpt_tag_o |-> $past(cpu_opfetch_i) && !bkpt_force_o)
		else $error("tag hit without opcode fetch");
	a_force_on_access: assert property (bkpt_force_o |-> $past(cpu_access_i))
		else $error("forced hit without access");
	a_bg_req_pulse: assert property (background_req_o |=> !background_req_o)
		else $error("background request longer than one cycle");
endmodule
bind debug_cmd_unit debug_cmd_unit_chk chk (.clk_sys_i, .rst_i, .debug_pin_o, .debug_pin_oe_o,
	.mem_req_o, .cpu_reg_we_o, .cpu_resume_o, .cpu_step_o, .cpu_halted_i, .cpu_opfetch_i,
	.cpu_access_i, .bkpt_force_o, .bkpt_tag_o, .background_req_o);
`default_nettype wire

// [sim/single_wire_debug_command_unit_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module single_wire_debug_command_unit_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic halted = 1'b0, op = 1'b0, acc_en = 1'b0;
	logic [15:0] addr = 16'h0000, pc = 16'h1357, ix = 16'h2468, sp = 16'h7BCD, e16, g16;
	logic [7:0] rdata = 8'h00, a = 8'hA1, f = 8'hC2, r8;
	logic [7:0] mem [0:255];
	logic [7:0] rc [0:4] = '{8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6F};
	wire pin_o, pin_oe, req, we, res, stp, rwe, bf, bt, bg, ack, host_low;
	wire [15:0] maddr, rwd;
	wire [7:0] wd;
	wire [2:0] sel;
	wire pin = ~host_low & (pin_oe ? pin_o : 1'b1);
	int n_fail = 0, n_tests = 0, n_bg = 0, n_res = 0, n_stp = 0, n_we = 0, n_mw = 0, n_bf = 0, n_bt = 0, n;
	always #25 clk_sys_i = ~clk_sys_i;
	initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3C;
	debug_cmd_unit dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .debug_pin_i(pin),
		.debug_pin_o(pin_o), .debug_pin_oe_o(pin_oe), .mem_req_o(req), .mem_we_o(we),
		.mem_addr_o(maddr), .mem_wdata_o(wd), .mem_rdata_i(rdata), .cpu_acc_i(a),
		.cpu_flags_i(f), .cpu_pc_i(pc), .cpu_index_i(ix), .cpu_sp_i(sp), .cpu_reg_sel_o(sel),
		.cpu_reg_wdata_o(rwd), .cpu_reg_we_o(rwe), .cpu_resume_o(res), .cpu_step_o(stp),
		.cpu_halted_i(halted), .cpu_addr_i(addr), .cpu_opfetch_i(op), .cpu_access_i(acc_en),
		.bkpt_force_o(bf), .bkpt_tag_o(bt), .background_req_o(bg), .ack_mode_o(ack));
	debug_host_pod host (.clk_sys_i(clk_sys_i), .pin_i(pin), .drive_low_o(host_low));
	// Memory, CPU registers and pulse counters
	always @(posedge clk_sys_i) begin
		if (req) begin
			if (we) mem[maddr[7:0]] <= wd;
			rdata <= mem[maddr[7:0]];
		end
		if (rwe) begin
			case (sel)
				3'd0: a <= rwd[7:0];
				3'd1: f <= rwd[7:0];
				3'd3: pc <= rwd;
				3'd4: ix <= rwd;
				3'd7: sp <= rwd;
				default: ;
			endcase
		end
		n_bg <= n_bg + bg;
		n_res <= n_res + res;
		n_stp <= n_stp + stp;
		n_we <= n_we + rwe;
		n_mw <= n_mw + (req & we);
		n_bf <= n_bf + bf;
		n_bt <= n_bt + bt;
	end
	// ----
	// Helpers
	// ----
	function automatic logic [15:0] rv(input logic [2:0] s);
		case (s)
			3'd0: return {8'h00, a};
			3'd1: return {8'h00, f};
			3'd3: return pc;
			3'd4: return ix;
			default: return sp;
		endcase
	endfunction
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		chk16({8'h00, g}, {8'h00, e});
	endtask
	task automatic stat(input logic [7:0] e);
		host.send8(8'hE4);
		host.recv8(r8);
		chk8(r8, e);
	endtask
	task automatic ctl(input logic [7:0] v);
		host.send8(8'hC4);
		host.send8(v);
	endtask
	// One CPU bus cycle at a chosen address, then the bus goes quiet
	task automatic bus(input logic o, input logic [15:0] ad);
		@(posedge clk_sys_i);
		op <= o;
		acc_en <= 1'b1;
		addr <= ad;
		@(posedge clk_sys_i);
		op <= 1'b0;
		acc_en <= 1'b0;
		addr <= 16'h0000;
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog: the tests take about 20000 cycles, so 50000 means a hang
	initial begin
		#(50000 * 50);
		n_fail++;
		tally_and_finish();
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		chk8({5'h00, pin_o, pin_oe, ack}, 8'h04);
		host.sync(n);
		chk16(16'(n), 16'h0080);
		stat(8'h00);
		ctl(8'hB0);
		stat(8'hB0);
		host.send8(8'hD5);
		host.gap();
		chk8({7'h00, ack}, 8'h01);
		stat(8'hB8);
		host.send8(8'hD6);
		host.gap();
		chk8({7'h00, ack}, 8'h00);
		host.send8(8'hC2);
		host.send16(16'h1234);
		host.send8(8'hE2);
		host.recv16(e16);
		chk16(e16, 16'h1234);
		bus(1'b0, 16'h1234);
		chk16(16'(n_bf * 16 + n_bt), 16'h0010);
		bus(1'b0, 16'h1235);
		chk16(16'(n_bf * 16 + n_bt), 16'h0010);
		ctl(8'hA0);
		bus(1'b0, 16'h1234);
		chk16(16'(n_bf * 16 + n_bt), 16'h0010);
		bus(1'b1, 16'h1234);
		chk16(16'(n_bf * 16 + n_bt), 16'h0011);
		ctl(8'h80);
		bus(1'b1, 16'h1234);
		chk16(16'(n_bf * 16 + n_bt), 16'h0011);
		host.send8(8'hC0);
		host.send16(16'h0155);
		host.send8(8'h5A);
		host.gap();
		chk8(mem[8'h55], 8'h5A);
		host.send8(8'hE0);
		host.send16(16'h0155);
		host.gap();
		host.recv8(r8);
		chk8(r8, 8'h5A);
		host.send8(8'hE1);
		host.send16(16'h0156);
		host.gap();
		for (int k = 0; k < 2; k++) begin
			if (k > 0) host.send8(8'hE8);
			host.recv8(r8);
			chk8(r8, 8'h80);
			host.recv8(r8);
			chk8(r8, 8'h6A);
		end
		host.send8(8'hC1);
		host.send16(16'h0157);
		host.send8(8'hA7);
		host.gap();
		host.recv8(r8);
		chk8(r8, 8'h80);
		chk8(mem[8'h57], 8'hA7);
		host.gap();
		host.send8(8'h90);
		host.gap();
		ctl(8'h00);
		host.send8(8'h90);
		host.gap();
		chk16(16'(n_bg), 16'h0001);
		host.send8(8'h48);
		host.send8(8'h77);
		repeat (600) @(posedge clk_sys_i);
		host.send8(8'hFF);
		repeat (600) @(posedge clk_sys_i);
		stat(8'h00);
		chk16(16'(n_we), 16'h0000);
		host.send8(8'hC0);
		host.send8(8'h01);
		repeat (600) @(posedge clk_sys_i);
		stat(8'h00);
		chk16(16'(n_mw), 16'h0002);
		halted <= 1'b1;
		stat(8'h40);
		foreach (rc[i]) begin
			host.send8(rc[i]);
			host.gap();
			e16 = rv(rc[i][2:0]);
			if (i < 2) begin
				host.recv8(r8);
				chk8(r8, e16[7:0]);
			end else begin
				host.recv16(g16);
				chk16(g16, e16);
			end
		end
		foreach (rc[i]) begin
			e16 = 16'(17 * (i + 1));
			host.send8(rc[i] - 8'h20);
			if (i < 2) host.send8(e16[7:0]);
			else host.send16(e16);
			host.gap();
			chk16(rv(rc[i][2:0]), e16);
		end
		host.send8(8'h70);
		host.gap();
		host.recv8(r8);
		chk8(r8, 8'h45 ^ 8'h3C);
		chk16(ix, 16'h0045);
		host.send8(8'h71);
		host.gap();
		host.recv8(r8);
		chk8(r8, 8'h40);
		host.recv8(r8);
		chk8(r8, 8'h46 ^ 8'h3C);
		host.send8(8'h50);
		host.send8(8'h99);
		host.gap();
		chk8(mem[8'h47], 8'h99);
		host.send8(8'h51);
		host.send8(8'h98);
		host.gap();
		host.recv8(r8);
		chk8(r8, 8'h40);
		chk8(mem[8'h48], 8'h98);
		host.send8(8'h10);
		host.gap();
		host.send8(8'h08);
		host.gap();
		host.send8(8'h18);
		host.gap();
		chk16(16'(n_stp * 16 + n_res), 16'h0012);
		tally_and_finish();
	end
endmodule
`default_nettype wire
